// [verification/sfhio_front_props.sv]
// Checker for the flash front end, bound to the top module's ports.
// Assumes the serial clock half period is at least four pclk cycles.
`timescale 1ns/1ps
module sfhio_front_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        serial_clock_pin,
  input wire logic        select_n_pin,
  input wire logic        data_line_three_in,
  input wire logic        data_line_one_out,
  input wire logic        data_line_zero_oe_n,
  input wire logic        data_line_one_oe_n,
  input wire logic        data_line_two_oe_n,
  input wire logic        data_line_three_oe_n,
  input wire logic        abort_operation
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       qe_sh;
  logic       prs_sh;
  logic [5:0] low_cnt;
  logic       rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  // ----------------------------------------------------------------
  // Shadow of configuration bits
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qe_sh  <= 1'b0;
      prs_sh <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 8'h00) qe_sh <= pwdata[1];
      if (paddr == 8'h04) prs_sh <= pwdata[7];
    end
  end
  // Saturates: a long pulse never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= 6'h00;
    else if (data_line_three_in || !prs_sh || qe_sh) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_hw_abort: assert property (
    low_cnt >= 6'h2d |-> abort_operation) else $error("no abort while reset pin low");
  chk_deselect_float: assert property (
    select_n_pin [*5] |-> data_line_zero_oe_n && data_line_one_oe_n
      && data_line_two_oe_n && data_line_three_oe_n) else $error("driving while deselected");
  chk_quad_lines_off: assert property (
    !qe_sh |-> data_line_two_oe_n && data_line_three_oe_n) else $error("quad lines without qe");
  chk_pause_float: assert property (
    (!select_n_pin && !data_line_three_in && !serial_clock_pin && !qe_sh && !prs_sh) [*5]
      |-> data_line_zero_oe_n && data_line_one_oe_n) else $error("driving while paused");
  chk_drive_on_fall: assert property (
    !data_line_one_oe_n && $changed(data_line_one_out) && !select_n_pin
      |-> !serial_clock_pin && !$past(serial_clock_pin)) else $error("output moved on rise");
  chk_qe_readback: assert property (
    rd_acc && paddr == 8'h00 |-> prdata[1] == qe_sh && !pslverr) else $error("qe readback");
  chk_unmapped_err: assert property (
    psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |-> pslverr)
    else $error("unmapped access without error");
  chk_qpi_needs_qe: assert property (
    rd_acc && paddr == 8'h0c && prdata[0] |-> qe_sh) else $error("four-line mode without qe");
  cover property (low_cnt == 6'h3f);
  cover property (!select_n_pin && !data_line_three_in && data_line_one_oe_n && !prs_sh);
  cover property (rd_acc && paddr == 8'h0c && prdata[0]);
endmodule // sfhio_front_props

bind sfhio_front sfhio_front_props chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .serial_clock_pin(serial_clock_pin), .select_n_pin(select_n_pin),
  .data_line_three_in(data_line_three_in), .data_line_one_out(data_line_one_out),
  .data_line_zero_oe_n(data_line_zero_oe_n), .data_line_one_oe_n(data_line_one_oe_n),
  .data_line_two_oe_n(data_line_two_oe_n), .data_line_three_oe_n(data_line_three_oe_n),
  .abort_operation(abort_operation)
);

// [verification/sfhio_front_tb_top.sv]
// Self-checking bench: APB tasks plus serial frames from the host model.
// Lets the APB slave stretch an access by up to 49 wait cycles (50 access cycles); waits stay bounded.
`timescale 1ns/1ps
module sfhio_front_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        sel_n;
  logic        abort;
  logic [3:0]  line;
  logic [3:0]  dout;
  logic [3:0]  doe_n;
  logic [3:0]  nib;
  logic [31:0] q;
  logic        e;
  int          miscompares = 0;
  int          tests_run = 0;
  logic [7:0]  quad_ops [4] = '{8'h6b, 8'heb, 8'he7, 8'he3};

  sfhio_front dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin(sclk), .select_n_pin(sel_n),
    .data_line_zero_in(line[0]), .data_line_zero_out(dout[0]), .data_line_zero_oe_n(doe_n[0]),
    .data_line_one_in(line[1]), .data_line_one_out(dout[1]), .data_line_one_oe_n(doe_n[1]),
    .data_line_two_in(line[2]), .data_line_two_out(dout[2]), .data_line_two_oe_n(doe_n[2]),
    .data_line_three_in(line[3]), .data_line_three_out(dout[3]),
    .data_line_three_oe_n(doe_n[3]), .abort_operation(abort)
  );
  sfhio_host_model hm_u (
    .pclk(pclk), .dev_out(dout), .dev_oe_n(doe_n), .sclk(sclk), .sel_n(sel_n), .line(line)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check(q & m, exp, "register read");
  endtask
  task automatic read_frame(input logic m3, input logic [7:0] op, input logic quad);
    hm_u.start(m3);
    hm_u.send(op, 1'b0);
    hm_u.rel(quad ? 4'h0 : 4'hc);
  endtask
  task automatic cmd(input logic [7:0] op, input logic four);
    hm_u.start(1'b0);
    hm_u.send(op, four);
    hm_u.stop();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(8'h00, 32'h0, 32'hffffffff);
    rd_chk(8'h04, 32'h0, 32'hffffffff);
    rd_chk(8'h0c, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, e}, 32'h1, "unmapped error");
    apb(1'b1, 8'h08, 32'ha5);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      read_frame(m[0], m ? 8'hbb : 8'h3b, 1'b0);
      for (int k = 3; k >= 0; k--) begin
        hm_u.rd(nib);
        check({30'h0, nib[1:0]}, 32'(8'ha5 >> (2 * k)) & 32'h3, "dual pair");
      end
      hm_u.stop();
    end
    $display("test dual done");
    read_frame(1'b0, 8'h6b, 1'b1);
    hm_u.rd(nib);
    check({28'h0, doe_n}, 32'hf, "quad refused");
    hm_u.stop();
    cmd(8'h38, 1'b0);
    rd_chk(8'h0c, 32'h0, 32'h1);
    apb(1'b1, 8'h00, 32'h2);
    foreach (quad_ops[i]) begin
      read_frame(1'b0, quad_ops[i], 1'b1);
      hm_u.rd(nib);
      check({28'h0, nib}, 32'ha, "quad hi");
      hm_u.rd(nib);
      check({28'h0, nib}, 32'h5, "quad lo");
      hm_u.stop();
    end
    $display("test quad done");
    cmd(8'h38, 1'b0);
    rd_chk(8'h0c, 32'h3801, 32'hff01);
    cmd(8'hff, 1'b1);
    rd_chk(8'h0c, 32'hff00, 32'hff01);
    cmd(8'h38, 1'b0);
    cmd(8'h66, 1'b1);
    cmd(8'h99, 1'b1);
    rd_chk(8'h0c, 32'h2, 32'h3);
    cmd(8'h38, 1'b0);
    rd_chk(8'h0c, 32'h2, 32'h3);
    repeat (420) @(posedge pclk);
    rd_chk(8'h0c, 32'h0, 32'h3);
    rd_chk(8'h00, 32'h2, 32'h2);
    $display("test four-line mode done");
    apb(1'b1, 8'h00, 32'h0);
    read_frame(1'b0, 8'h3b, 1'b0);
    hm_u.rd(nib);
    hm_u.set_line3(1'b0);
    repeat (6) @(posedge pclk);
    check({30'h0, doe_n[1:0]}, 32'h3, "float in pause");
    rd_chk(8'h0c, 32'h4, 32'h4);
    hm_u.set_line3(1'b1);
    hm_u.rd(nib);
    check({30'h0, nib[1:0]}, 32'h2, "resumed pair");
    hm_u.stop();
    $display("test pause done");
    apb(1'b1, 8'h04, 32'h80);
    hm_u.set_line3(1'b0);
    repeat (60) @(posedge pclk);
    check({31'h0, abort}, 32'h1, "abort while low");
    rd_chk(8'h0c, 32'h20, 32'h20);
    hm_u.set_line3(1'b1);
    repeat (10) @(posedge pclk);
    check({31'h0, abort}, 32'h0, "abort released");
    $display("test hardware reset done");
    tally_and_finish();
  end
endmodule // sfhio_front_tb_top

// [verification/sfhio_host_model.sv]
// Bus master model on the serial side: clock, select and data lines.
// Assumes pclk is 8x the serial clock; all changes land right after pclk rises.
`timescale 1ns/1ps
module sfhio_host_model (
  input  wire logic       pclk,
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe_n,
  output logic            sclk,
  output logic            sel_n,
  output logic [3:0]      line
);
  logic [3:0] drv_val = 4'hf;
  logic [3:0] drv_en  = 4'hf;
  logic       m3      = 1'b0;
  logic       spin    = 1'b0;
  initial sclk = 1'b0;
  initial sel_n = 1'b1;
  always @(posedge pclk) spin <= ~spin;
  // Released: lines two and three pull up, zero and one toggle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[i] = !dev_oe_n[i] ? dev_out[i] : drv_en[i] ? drv_val[i] : (i > 1) ? 1'b1 : spin;
    end
  end
  task automatic half();
    repeat (4) @(posedge pclk);
  endtask
  task automatic start(input logic mode3);
    @(posedge pclk);
    m3 = mode3;
    sclk <= mode3;
    half();
    sel_n <= 1'b0;
    half();
    sclk <= 1'b0;
    half();
  endtask
  task automatic put(input logic [3:0] v);
    drv_val <= v;
    half();
    sclk <= 1'b1;
    half();
    sclk <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic four);
    if (four) begin
      put(b[7:4]);
      put(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) put({3'b111, b[i]});
    end
  endtask
  task automatic rel(input logic [3:0] en);
    drv_en <= en;
  endtask
  task automatic rd(output logic [3:0] v);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    v = line;
    @(posedge pclk);
    sclk <= 1'b1;
    repeat (3) @(posedge pclk);
    sclk <= 1'b0;
  endtask
  task automatic stop();
    half();
    sclk <= m3;
    half();
    sel_n <= 1'b1;
    drv_en <= 4'hf;
    drv_val <= 4'hf;
    half();
  endtask
  task automatic set_line3(input logic lvl);
    @(posedge pclk);
    drv_val[3] <= lvl;
  endtask
endmodule // sfhio_host_model

// [verilog/sfhio_front.sv]
// Serial flash host interface front end: pins, modes, pause and resets.
// Assumes pclk is far faster than the serial clock; APB slave, no wait states.
//
// How it works
// - Only clock modes 0 and 3 are served; idle clock level is ignored.
// - Inputs sampled on serial clock rise, outputs updated on its fall.
// - Cycles count fall to fall; mode 0 starts at select fall.
// - Dual reads 3Bh and BBh drive data lines zero and one.
// - Quad reads 6Bh, EBh, E7h, E3h drive all four data lines.
// - Quad instructions are accepted only while quad enable is set.
// - 38h enters four-line instruction mode, FFh leaves it.
// - Opcode takes two clocks on four lines, else eight on one.
// - Modes exclusive; reset and soft reset return to serial mode.
// - Entering four-line mode needs quad enable set first.
// - Pause works only while selected and outside quad operations.
// - Pause starts on pause pin fall if clock low, else next fall.
// - Pause ends on pause pin rise if clock low, else next fall.
// - While paused outputs float, inputs and clock ignored, state kept.
// - Soft reset is 66h then 99h, in either instruction mode.
// - After soft reset, about 10us busy rejecting all commands.
// - Select bit picks pause (0, default) or hardware reset (1).
// - Long low reset pin aborts, restores power-on state, blocks commands.
// - Quad enable set turns the shared pin into a data line.
// - Hardware reset overrides every other input.
// - Quad enable is bit 1 of status word two.
// - Resets reload volatile quad enable from its non-volatile copy.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module sfhio_front (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_pin,
  input  wire logic        select_n_pin,
  input  wire logic        data_line_zero_in,
  output logic             data_line_zero_out,
  output logic             data_line_zero_oe_n,
  input  wire logic        data_line_one_in,
  output logic             data_line_one_out,
  output logic             data_line_one_oe_n,
  input  wire logic        data_line_two_in,
  output logic             data_line_two_out,
  output logic             data_line_two_oe_n,
  input  wire logic        data_line_three_in,
  output logic             data_line_three_out,
  output logic             data_line_three_oe_n,
  output logic             abort_operation
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic       sclk_s;
  logic       sel_n_s;
  logic [3:0] dq_s;
  logic       sclk_d;
  logic       rise;
  logic       fall;

  sfhio_sync #(.W(6), .RESET_VALUE(6'h1e)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({serial_clock_pin, select_n_pin, data_line_three_in,
                data_line_two_in, data_line_one_in, data_line_zero_in}),
    .sync_out (pins_s)
  );

  assign sclk_s  = pins_s[5];
  assign sel_n_s = pins_s[4];
  assign dq_s    = pins_s[3:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // Either idle level works: edges, not levels, drive the shifters
  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic       qe_nv;
  logic       qe;
  logic       pause_or_reset_select;
  logic [7:0] tx_data;
  logic       por_event;
  logic       apb_wr;
  logic       apb_rd_hit;

  assign apb_wr = psel & penable & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qe_nv <= 1'b0;
    end else if (apb_wr && paddr == sfhio_pkg::REG_STATUS_TWO) begin
      qe_nv <= pwdata[sfhio_pkg::QE_BIT];
    end
  end

  // Volatile copy steers the pins; a reset brings it back to stored value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qe <= 1'b0;
    end else if (por_event) begin
      qe <= qe_nv;
    end else if (apb_wr && paddr == sfhio_pkg::REG_STATUS_TWO) begin
      qe <= pwdata[sfhio_pkg::QE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_or_reset_select <= 1'b0;
    end else if (apb_wr && paddr == sfhio_pkg::REG_STATUS_THREE) begin
      pause_or_reset_select <= pwdata[sfhio_pkg::PRS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= sfhio_pkg::TX_DATA_RESET;
    end else if (apb_wr && paddr == sfhio_pkg::REG_TX_DATA) begin
      tx_data <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Hardware reset through the shared pin
  // ----------------------------------------------------------------
  logic                            hrst_active;
  logic                            hrst_low;
  logic [sfhio_pkg::TIMER_W-1:0]   hrst_cnt;
  logic                            hrst_fire;

  // Quad enable hands the pin over to data, killing both pin functions
  assign hrst_active = pause_or_reset_select & ~qe;
  assign hrst_low    = hrst_active & ~dq_s[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hrst_cnt <= '0;
    end else if (!hrst_low) begin
      hrst_cnt <= '0;
    end else if (hrst_cnt != sfhio_pkg::TIMER_W'(sfhio_pkg::HARD_RESET_CYC)) begin
      hrst_cnt <= hrst_cnt + 1'b1;
    end
  end

  // Fires once per low pulse, after the full width
  assign hrst_fire = hrst_low &&
                     hrst_cnt == sfhio_pkg::TIMER_W'(sfhio_pkg::HARD_RESET_CYC - 1);

  // ----------------------------------------------------------------
  // Pause
  // ----------------------------------------------------------------
  logic paused;
  logic pause_allowed;
  logic quad_op;

  // A high clock defers any pause pin change to the next fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paused <= 1'b0;
    end else if (hrst_low || !pause_allowed) begin
      paused <= 1'b0;
    end else if (!sclk_s) begin
      paused <= ~dq_s[3];
    end
  end

  assign pause_allowed = ~sel_n_s & ~pause_or_reset_select & ~qe & ~quad_op;

  // ----------------------------------------------------------------
  // Instruction engine
  // ----------------------------------------------------------------
  sfhio_pkg::sfhio_state_t state;
  logic       four_line_instruction_mode;
  logic [7:0] shift_in;
  logic [2:0] bit_cnt;
  logic       rst_enabled;
  logic       dual_op;
  logic [7:0] last_opcode;
  logic [7:0] shift_out;
  logic [3:0] out_bits;
  logic       driving;
  logic [sfhio_pkg::TIMER_W-1:0] busy_cnt;
  logic       busy;
  logic       soft_fire;
  logic       step;
  logic       opcode_done;
  logic [7:0] next_shift_in;
  logic [7:0] opcode;

  function automatic logic is_quad(input logic [7:0] op);
    is_quad = op inside {sfhio_pkg::OP_QUAD_OUT, sfhio_pkg::OP_QUAD_IO,
                         sfhio_pkg::OP_QUAD_WORD, sfhio_pkg::OP_QUAD_OCTAL};
  endfunction

  function automatic logic is_dual(input logic [7:0] op);
    is_dual = op inside {sfhio_pkg::OP_DUAL_OUT, sfhio_pkg::OP_DUAL_IO};
  endfunction

  // Nothing on the link moves while paused, in reset or deselected
  assign step = ~paused & ~hrst_low & ~sel_n_s;

  always_comb begin
    if (four_line_instruction_mode) begin
      next_shift_in = {shift_in[3:0], dq_s};
    end else begin
      next_shift_in = {shift_in[6:0], dq_s[0]};
    end
  end

  assign opcode_done = step && rise && state == sfhio_pkg::sfhio_opcode &&
                       bit_cnt == (four_line_instruction_mode ? 3'd1 : 3'd7);
  assign opcode      = next_shift_in;
  assign soft_fire   = opcode_done && !busy && rst_enabled &&
                       opcode == sfhio_pkg::OP_RESET;
  assign por_event   = soft_fire | hrst_fire;
  assign busy        = busy_cnt != '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= '0;
    end else if (soft_fire) begin
      busy_cnt <= sfhio_pkg::TIMER_W'(sfhio_pkg::SOFT_RESET_CYC);
    end else if (busy) begin
      busy_cnt <= busy_cnt - 1'b1;
    end
  end

  // Bits count from select fall, so mode 0 and 3 both start cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_in <= '0;
      bit_cnt  <= '0;
    end else if (sel_n_s || hrst_low) begin
      shift_in <= '0;
      bit_cnt  <= '0;
    end else if (step && rise && state == sfhio_pkg::sfhio_opcode) begin
      shift_in <= next_shift_in;
      bit_cnt  <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sfhio_pkg::sfhio_opcode;
    end else if (sel_n_s || hrst_low) begin
      state <= sfhio_pkg::sfhio_opcode;
    end else if (opcode_done) begin
      case (state)
        sfhio_pkg::sfhio_opcode: begin
          if (busy) begin
            state <= sfhio_pkg::sfhio_ignore;
          end else if (is_dual(opcode) || (qe && is_quad(opcode))) begin
            state <= sfhio_pkg::sfhio_data;
          end else begin
            state <= sfhio_pkg::sfhio_ignore;
          end
        end
        default: state <= sfhio_pkg::sfhio_ignore;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      four_line_instruction_mode <= 1'b0;
    end else if (por_event) begin
      four_line_instruction_mode <= 1'b0;
    end else if (opcode_done && !busy && opcode == sfhio_pkg::OP_ENTER_QPI && qe) begin
      four_line_instruction_mode <= 1'b1;
    end else if (opcode_done && !busy && opcode == sfhio_pkg::OP_EXIT_QPI) begin
      four_line_instruction_mode <= 1'b0;
    end
  end

  // Enable must be the very command before the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_enabled <= 1'b0;
    end else if (hrst_low) begin
      rst_enabled <= 1'b0;
    end else if (opcode_done) begin
      rst_enabled <= !busy && opcode == sfhio_pkg::OP_RST_ENABLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_op     <= 1'b0;
      quad_op     <= 1'b0;
      last_opcode <= '0;
    end else if (sel_n_s || hrst_low) begin
      dual_op <= 1'b0;
      quad_op <= 1'b0;
    end else if (opcode_done && !busy) begin
      last_opcode <= opcode;
      dual_op     <= is_dual(opcode);
      quad_op     <= qe && is_quad(opcode);
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  // Only a falling edge moves outputs, giving the master a full half cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_out <= '0;
      out_bits  <= '0;
      driving   <= 1'b0;
    end else if (state != sfhio_pkg::sfhio_data || sel_n_s || hrst_low) begin
      shift_out <= tx_data;
      out_bits  <= '0;
      driving   <= 1'b0;
    end else if (step && fall) begin
      driving <= 1'b1;
      if (quad_op) begin
        out_bits  <= shift_out[7:4];
        shift_out <= {shift_out[3:0], shift_out[7:4]};
      end else begin
        out_bits  <= {2'b00, shift_out[7:6]};
        shift_out <= {shift_out[5:0], shift_out[7:6]};
      end
    end
  end

  assign data_line_zero_out   = out_bits[0];
  assign data_line_one_out    = out_bits[1];
  assign data_line_two_out    = out_bits[2];
  assign data_line_three_out  = out_bits[3];
  assign data_line_zero_oe_n  = ~(driving & ~paused);
  assign data_line_one_oe_n   = ~(driving & ~paused);
  assign data_line_two_oe_n   = ~(driving & quad_op);
  assign data_line_three_oe_n = ~(driving & quad_op);
  assign abort_operation      = hrst_low | busy;

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  assign pready     = 1'b1;
  assign apb_rd_hit = paddr inside {sfhio_pkg::REG_STATUS_TWO, sfhio_pkg::REG_STATUS_THREE,
                                    sfhio_pkg::REG_TX_DATA, sfhio_pkg::REG_LINK_STATE};
  assign pslverr    = psel & penable & ~apb_rd_hit;

  always_comb begin
    prdata = '0;
    case (paddr)
      sfhio_pkg::REG_STATUS_TWO:   prdata[sfhio_pkg::QE_BIT] = qe;
      sfhio_pkg::REG_STATUS_THREE: prdata[sfhio_pkg::PRS_BIT] = pause_or_reset_select;
      sfhio_pkg::REG_TX_DATA:      prdata[7:0] = tx_data;
      sfhio_pkg::REG_LINK_STATE: begin
        prdata[sfhio_pkg::LS_QPI_BIT]    = four_line_instruction_mode;
        prdata[sfhio_pkg::LS_BUSY_BIT]   = busy;
        prdata[sfhio_pkg::LS_PAUSED_BIT] = paused;
        prdata[sfhio_pkg::LS_DUAL_BIT]   = dual_op;
        prdata[sfhio_pkg::LS_QUAD_BIT]   = quad_op;
        prdata[sfhio_pkg::LS_HRST_BIT]   = hrst_low;
        prdata[sfhio_pkg::LS_OPCODE_LSB +: 8] = last_opcode;
      end
      default: prdata = '0;
    endcase
  end
endmodule // sfhio_front

// [verilog/sfhio_pkg.sv]
// Constants for the serial flash host interface front end.
// Assumes a 40 MHz APB clock; the timing, opcode and register numbers live here.
package sfhio_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SOFT_RESET_NS   = 10000;
  localparam int HARD_RESET_NS   = 1000;
  localparam int SOFT_RESET_CYC  = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HARD_RESET_CYC  = (HARD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W         = 12;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO    = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD  = 8'he7;
  localparam logic [7:0] OP_QUAD_OCTAL = 8'he3;
  localparam logic [7:0] OP_ENTER_QPI  = 8'h38;
  localparam logic [7:0] OP_EXIT_QPI   = 8'hff;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET      = 8'h99;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS_TWO   = 8'h00;
  localparam logic [7:0] REG_STATUS_THREE = 8'h04;
  localparam logic [7:0] REG_TX_DATA      = 8'h08;
  localparam logic [7:0] REG_LINK_STATE   = 8'h0c;
  localparam int QE_BIT          = 1;
  localparam int PRS_BIT         = 7;
  localparam int LS_QPI_BIT      = 0;
  localparam int LS_BUSY_BIT     = 1;
  localparam int LS_PAUSED_BIT   = 2;
  localparam int LS_DUAL_BIT     = 3;
  localparam int LS_QUAD_BIT     = 4;
  localparam int LS_HRST_BIT     = 5;
  localparam int LS_OPCODE_LSB   = 8;
  localparam logic [7:0] TX_DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Interface state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {sfhio_opcode, sfhio_data, sfhio_ignore} sfhio_state_t;
endpackage

// [verilog/sfhio_sync.sv]
// Two flip-flop synchroniser for a bundle of independent pin levels.
// Assumes each bit is a level; no multi-bit coherence is promised.
`timescale 1ns/1ps
module sfhio_sync #(
  parameter int           W           = 1,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // sfhio_sync
